// >>> src/sbcirq_top.sv
// Interrupt pulse logic with APB registers and config capture
//
// Function
// [RQ1] Interrupt pulses low 100 us, then releases
// [RQ2] At least 100 us high between pulses
// [RQ3] Interrupt never changes operating mode
// [RQ4] Class 0: only enabled wake status interrupts
// [RQ5] Wake event needs its source enabled
// [RQ6] Class 1: failures too, level status never
// [RQ7] Reset-causing and device flags never interrupt
// [RQ8] Stop request with wake bits set pulses
// [RQ9] Readable status updated at pulse falling edge
// [RQ10] Events latched until host clears them
// [RQ11] Host re-reads after clearing to confirm
// [RQ12] Init mode samples pin for configuration
// [RQ13] Config level filtered 7 us first
// [RQ14] Events during pulse or gap give one later pulse
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
module sbcirq_top #(
  parameter int NWK = 8,
  parameter int PULSE_CYC = sbcirq_pkg::PULSE_CYC,
  parameter int GAP_CYC = sbcirq_pkg::GAP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NWK-1:0] wake_evt_a,
  input wire logic [NWK-1:0] wake_evt_b,
  input wire logic [31:0] fail_evt,
  input wire logic [NWK-1:0] wake_level,
  input wire logic int_pin_in,
  output logic int_pin_out,
  output logic int_pin_oe_n,
  output logic stop_req,
  output logic cfg_level,
  output logic cfg_valid,
  output logic irq
);
  localparam int CFG_CYC = sbcirq_pkg::CFG_FILT_CYC; // Filter length

  // ==========================================================
  // Registers
  // ==========================================================
  logic [31:0] ctrl_r;         // Control register
  logic [NWK-1:0] wk_a_r;      // Internal wake latch a
  logic [NWK-1:0] wk_b_r;      // Internal wake latch b
  logic [31:0] fail_r;         // Internal failure latch
  logic [NWK-1:0] wk_a_vis_r;  // Readable wake status a
  logic [NWK-1:0] wk_b_vis_r;  // Readable wake status b
  logic [31:0] fail_vis_r;     // Readable failure status
  logic [31:0] wk_en_r;        // Wake enables, a low, b high half
  logic [NWK-1:0] lvl_r;       // Level snapshot, not latched
  logic [1:0] imask_r;         // Interrupt mask
  logic [1:0] istat_r;         // Interrupt status
  logic stop_req_r;            // Stop request pulse
  logic pending_r;             // Pulse owed
  logic cfg_level_r;           // Accepted config level
  logic cfg_valid_r;           // Config accepted
  sbcirq_pkg::sbcirq_state_type state_r; // Sequencer state
  sbcirq_pkg::sbcirq_state_type state_nxt; // Next state

  logic wr;                    // Write strobe
  logic rd;                    // Read strobe
  logic class_global;          // Class select
  logic init_mode;             // Initialisation mode
  logic [NWK-1:0] en_a;        // Enables for a
  logic [NWK-1:0] en_b;        // Enables for b
  logic [NWK-1:0] new_a;       // New enabled wake events a
  logic [NWK-1:0] new_b;       // New enabled wake events b
  logic [31:0] new_fail;       // New interrupting failures
  logic trig;                  // Trigger this cycle
  logic stop_trig;             // Stop entry with wake bits set
  logic fall;                  // Pulse falling edge
  logic pulse_done;            // Low time over
  logic gap_done;              // Gap over
  logic pin_sync;              // Synchronised pin
  logic cfg_done;              // Filter expired
  logic cfg_load;              // Restart filter
  logic [NWK-1:0] clr_a;       // Clear mask a
  logic [NWK-1:0] clr_b;       // Clear mask b
  logic [31:0] clr_f;          // Clear mask failures

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign class_global = ctrl_r[sbcirq_pkg::CTRL_GLOBAL_BIT];
  assign init_mode = ctrl_r[sbcirq_pkg::CTRL_INIT_BIT];
  assign en_a = wk_en_r[NWK-1:0];
  assign en_b = wk_en_r[16+NWK-1:16];

  // ==========================================================
  // Event qualification
  // ==========================================================
  // Only enabled wake sources latch and trigger
  assign new_a = wake_evt_a & en_a & ~wk_a_r; // [RQ5] [RQ4]
  assign new_b = wake_evt_b & en_b & ~wk_b_r; // [RQ5] [RQ4]
  // Failures count only in global class, excluded bits never
  assign new_fail = fail_evt & ~sbcirq_pkg::FAIL_EXCL & ~fail_r
                    & {32{class_global}}; // [RQ6] [RQ7]
  // Stop command while wake bits remain set
  assign stop_trig = wr && (paddr == sbcirq_pkg::OFF_CTRL)
                     && pwdata[sbcirq_pkg::CTRL_STOP_BIT]
                     && ((|wk_a_r) || (|wk_b_r)); // [RQ8]
  assign trig = !init_mode && ((|new_a) || (|new_b) || (|new_fail) || stop_trig);

  // Write-one-to-clear masks
  assign clr_a = (wr && paddr == sbcirq_pkg::OFF_WK_A) ? pwdata[NWK-1:0] : '0;
  assign clr_b = (wr && paddr == sbcirq_pkg::OFF_WK_B) ? pwdata[NWK-1:0] : '0;
  assign clr_f = (wr && paddr == sbcirq_pkg::OFF_FAIL) ? pwdata : '0;

  // ==========================================================
  // Status latches
  // ==========================================================
  // Events stick until cleared; a new event wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wk_a_r <= '0;
      wk_b_r <= '0;
      fail_r <= '0;
    end else begin
      wk_a_r <= (wk_a_r & ~clr_a) | (wake_evt_a & en_a); // [RQ10]
      wk_b_r <= (wk_b_r & ~clr_b) | (wake_evt_b & en_b); // [RQ10]
      fail_r <= (fail_r & ~clr_f) | fail_evt; // [RQ10]
    end
  end

  // Readable copies refresh at the falling edge, clears act at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wk_a_vis_r <= '0;
      wk_b_vis_r <= '0;
      fail_vis_r <= '0;
    end else if (fall) begin
      wk_a_vis_r <= (wk_a_r & ~clr_a) | (wake_evt_a & en_a); // [RQ9]
      wk_b_vis_r <= (wk_b_r & ~clr_b) | (wake_evt_b & en_b); // [RQ9]
      fail_vis_r <= (fail_r & ~clr_f) | fail_evt; // [RQ9]
    end else begin
      wk_a_vis_r <= wk_a_vis_r & ~clr_a; // [RQ10]
      wk_b_vis_r <= wk_b_vis_r & ~clr_b; // [RQ10]
      fail_vis_r <= fail_vis_r & ~clr_f; // [RQ10]
    end
  end

  // Level status follows the inputs, never latched or interrupting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_r <= '0;
    end else begin
      lvl_r <= wake_level; // [RQ6]
    end
  end

  // ==========================================================
  // Pulse sequencer
  // ==========================================================
  sbcirq_timer #(.WIDTH(16)) u_pulse_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .load(fall),
    .load_val(16'(PULSE_CYC - 1)),
    .done(pulse_done)
  );

  sbcirq_timer #(.WIDTH(16)) u_gap_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .load(state_r == sbcirq_pkg::SBCIRQ_LOW && pulse_done),
    .load_val(16'(GAP_CYC - 1)),
    .done(gap_done)
  );

  // Falling edge: idle with work to do
  assign fall = (state_r == sbcirq_pkg::SBCIRQ_IDLE) && (trig || pending_r) && !init_mode;

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sbcirq_pkg::SBCIRQ_IDLE: begin
        if (fall) begin
          state_nxt = sbcirq_pkg::SBCIRQ_LOW;
        end
      end
      sbcirq_pkg::SBCIRQ_LOW: begin
        if (pulse_done) begin
          state_nxt = sbcirq_pkg::SBCIRQ_GAP; // [RQ1]
        end
      end
      sbcirq_pkg::SBCIRQ_GAP: begin
        if (gap_done) begin
          state_nxt = sbcirq_pkg::SBCIRQ_IDLE; // [RQ2]
        end
      end
      default: begin
        state_nxt = sbcirq_pkg::SBCIRQ_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= sbcirq_pkg::SBCIRQ_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Events outside idle are held as one pending pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_r <= 1'b0;
    end else if (fall) begin
      pending_r <= 1'b0;
    end else if (trig) begin
      pending_r <= 1'b1; // [RQ14]
    end
  end

  // Stop request strobe goes out unchanged; pulses never touch mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_req_r <= 1'b0;
    end else begin
      stop_req_r <= wr && (paddr == sbcirq_pkg::OFF_CTRL)
                    && pwdata[sbcirq_pkg::CTRL_STOP_BIT]; // [RQ3]
    end
  end

  // ==========================================================
  // Configuration capture
  // ==========================================================
  sbcirq_sync u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(int_pin_in),
    .dout(pin_sync)
  );

  assign cfg_load = init_mode && (pin_sync != cfg_level_r);

  sbcirq_timer #(.WIDTH(16)) u_cfg_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .load(cfg_load),
    .load_val(16'(CFG_CYC - 1)),
    .done(cfg_done)
  );

  // Level stable for the filter time is accepted in init mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_level_r <= 1'b0;
      cfg_valid_r <= 1'b0;
    end else if (cfg_load) begin
      cfg_level_r <= pin_sync;
      cfg_valid_r <= 1'b0;
    end else if (init_mode && cfg_done) begin
      cfg_valid_r <= 1'b1; // [RQ12] [RQ13]
    end
  end

  // ==========================================================
  // Block interrupt status and mask
  // ==========================================================
  // Sticky events, set wins over write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_r <= 2'b00;
    end else begin
      istat_r <= (istat_r & ~((wr && paddr == sbcirq_pkg::OFF_ISTAT) ? pwdata[1:0] : 2'b00))
                 | {cfg_load == 1'b0 && init_mode && cfg_done && !cfg_valid_r, fall};
    end
  end

  // Control, enables and mask writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= sbcirq_pkg::CTRL_RST;
      wk_en_r <= sbcirq_pkg::WK_EN_RST;
      imask_r <= 2'b00;
    end else if (wr) begin
      case (paddr)
        sbcirq_pkg::OFF_CTRL: begin
          ctrl_r <= pwdata & 32'h0000_0005;
        end
        sbcirq_pkg::OFF_WK_EN: begin
          wk_en_r <= pwdata;
        end
        sbcirq_pkg::OFF_IMASK: begin
          imask_r <= pwdata[1:0];
        end
        default: begin
          ctrl_r <= ctrl_r;
        end
      endcase
    end
  end

  // ==========================================================
  // APB read
  // ==========================================================
  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd) begin
      case (paddr)
        sbcirq_pkg::OFF_CTRL: prdata <= ctrl_r;
        sbcirq_pkg::OFF_WK_A: prdata <= 32'(wk_a_vis_r);
        sbcirq_pkg::OFF_WK_B: prdata <= 32'(wk_b_vis_r);
        sbcirq_pkg::OFF_FAIL: prdata <= fail_vis_r;
        sbcirq_pkg::OFF_WK_EN: prdata <= wk_en_r;
        sbcirq_pkg::OFF_LVL: prdata <= 32'(lvl_r);
        sbcirq_pkg::OFF_IMASK: prdata <= 32'(imask_r);
        sbcirq_pkg::OFF_ISTAT: prdata <= 32'(istat_r);
        sbcirq_pkg::OFF_CFG: prdata <= {30'h0000_0000, cfg_valid_r, cfg_level_r};
        default: prdata <= '0;
      endcase
    end
  end

  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // ==========================================================
  // Outputs
  // ==========================================================
  assign int_pin_out = (state_r != sbcirq_pkg::SBCIRQ_LOW); // [RQ1]
  assign int_pin_oe_n = init_mode; // [RQ12]
  assign stop_req = stop_req_r;
  assign cfg_level = cfg_level_r;
  assign cfg_valid = cfg_valid_r;
  assign irq = |(istat_r & imask_r);
endmodule

// >>> src/sbcirq_pkg.sv
// Package: constants for the interrupt pulse logic
package sbcirq_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int CLK_MHZ = 50;                       // pclk rate in MHz
  localparam int PULSE_US = 100;                     // Low pulse width in us
  localparam int GAP_US = 100;                       // Least high time in us
  localparam int CFG_FILT_US = 7;                    // Config filter in us
  localparam int PULSE_CYC = PULSE_US * CLK_MHZ;     // 5000 cycles
  localparam int GAP_CYC = GAP_US * CLK_MHZ;         // 5000 cycles
  localparam int CFG_FILT_CYC = CFG_FILT_US * CLK_MHZ; // 350 cycles

  // ==========================================================
  // Register byte offsets
  // ==========================================================
  localparam logic [7:0] OFF_CTRL = 8'h00;     // Control
  localparam logic [7:0] OFF_WK_A = 8'h04;     // Wake event status a
  localparam logic [7:0] OFF_WK_B = 8'h08;     // Wake event status b
  localparam logic [7:0] OFF_FAIL = 8'h0C;     // Failure status
  localparam logic [7:0] OFF_WK_EN = 8'h10;    // Wake source enables
  localparam logic [7:0] OFF_LVL = 8'h14;      // Wake level status
  localparam logic [7:0] OFF_IMASK = 8'h18;    // Interrupt mask
  localparam logic [7:0] OFF_ISTAT = 8'h1C;    // Interrupt status
  localparam logic [7:0] OFF_CFG = 8'h20;      // Captured config

  // ==========================================================
  // Control fields and reset values
  // ==========================================================
  localparam int CTRL_GLOBAL_BIT = 0;          // Class select
  localparam int CTRL_STOP_BIT = 1;            // Stop-mode request strobe
  localparam int CTRL_INIT_BIT = 2;            // Initialisation mode
  localparam logic [31:0] CTRL_RST = 32'h0000_0004;   // Init on reset
  localparam logic [31:0] WK_EN_RST = 32'h0000_0000;  // No wake sources
  localparam int ISTAT_PULSE_BIT = 0;          // Pulse issued event
  localparam int ISTAT_CFG_BIT = 1;            // Config captured event

  // Failure bits that never interrupt (reset-causing and flags)
  localparam logic [31:0] FAIL_EXCL = 32'h0000_00FF;

  // Pulse sequencer states
  typedef enum logic [1:0] {SBCIRQ_IDLE, SBCIRQ_LOW, SBCIRQ_GAP} sbcirq_state_type;

endpackage

// >>> src/sbcirq_timer.sv
// Down counter used for pulse, gap and filter timing
`timescale 1ns/1ps
module sbcirq_timer #(
  parameter int WIDTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  output logic done
);
  logic [WIDTH-1:0] cnt_r; // Remaining cycles

  // ==========================================================
  // Counter
  // ==========================================================
  // Load restarts, otherwise count to zero and hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign done = (cnt_r == '0) && !load; // Expired
endmodule

// >>> src/sbcirq_sync.sv
// Two flip-flop synchroniser for a pin level
`timescale 1ns/1ps
module sbcirq_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic din,
  output logic dout
);
  logic meta_r; // First stage, read only by the second
  logic sync_r; // Second stage

  // ==========================================================
  // Synchroniser
  // ==========================================================
  // Pin idles high, so reset to one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  assign dout = sync_r;
endmodule

// >>> tb/sbcirq_top_asserts.sv
// Checker module for the interrupt pulse logic ports
`timescale 1ns/1ps
module sbcirq_top_asserts #(
  parameter int PULSE_CYC = 20,
  parameter int GAP_CYC = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic int_pin_in,
  input wire logic int_pin_out,
  input wire logic int_pin_oe_n,
  input wire logic stop_req,
  input wire logic cfg_level,
  input wire logic cfg_valid
);
  // ==========================================================
  // Helper logic
  // ==========================================================
  int lo_cnt_r; // Low samples of the pin
  int hi_cnt_r; // High samples of the pin
  int stab_cnt_r; // Samples with a steady pin input
  logic pin_q_r; // Previous pin input
  logic stop_wr; // Control write carrying the stop strobe
  assign stop_wr = psel && penable && pwrite && paddr == sbcirq_pkg::OFF_CTRL
    && pwdata[sbcirq_pkg::CTRL_STOP_BIT];
  // Pulse and gap lengths; gap starts full so the first pulse is legal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_cnt_r <= 0;
      hi_cnt_r <= GAP_CYC;
    end else begin
      lo_cnt_r <= int_pin_out ? 0 : lo_cnt_r + 1;
      hi_cnt_r <= int_pin_out ? hi_cnt_r + 1 : 0;
    end
  end
  // Steady time of the pin level seen by the config filter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q_r <= 1'b1;
      stab_cnt_r <= 0;
    end else begin
      pin_q_r <= int_pin_in;
      stab_cnt_r <= (int_pin_in == pin_q_r) ? stab_cnt_r + 1 : 0;
    end
  end
  // ==========================================================
  // Properties
  // ==========================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_pulse_width;
    $rose(int_pin_out) |-> lo_cnt_r == PULSE_CYC;
  endproperty
  property p_pulse_max;
    !int_pin_out |-> lo_cnt_r < PULSE_CYC;
  endproperty
  property p_gap;
    $fell(int_pin_out) |-> hi_cnt_r >= GAP_CYC;
  endproperty
  property p_init_quiet;
    int_pin_oe_n |-> int_pin_out;
  endproperty
  property p_stop_cause;
    stop_wr |=> stop_req ##1 !stop_req;
  endproperty
  property p_stop_only;
    stop_req |-> $past(stop_wr);
  endproperty
  property p_cfg_filter;
    $rose(cfg_valid) |-> stab_cnt_r >= sbcirq_pkg::CFG_FILT_CYC;
  endproperty
  property p_cfg_level;
    $rose(cfg_valid) |-> cfg_level == int_pin_in;
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("pulse width off");
  a_pulse_max: assert property (p_pulse_max) else $error("pulse too long");
  a_gap: assert property (p_gap) else $error("gap too short");
  a_init_quiet: assert property (p_init_quiet) else $error("pulse in init");
  a_stop_cause: assert property (p_stop_cause) else $error("stop strobe lost");
  a_stop_only: assert property (p_stop_only) else $error("mode change");
  a_cfg_filter: assert property (p_cfg_filter) else $error("config unfiltered");
  a_cfg_level: assert property (p_cfg_level) else $error("config level wrong");
  c_pulse: cover property ($fell(int_pin_out));
  c_stop: cover property (stop_req);
  c_cfg: cover property ($rose(cfg_valid));
endmodule

bind sbcirq_top sbcirq_top_asserts #(.PULSE_CYC(PULSE_CYC), .GAP_CYC(GAP_CYC))
  sbcirq_top_asserts_inst (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .int_pin_in(int_pin_in),
  .int_pin_out(int_pin_out),
  .int_pin_oe_n(int_pin_oe_n),
  .stop_req(stop_req),
  .cfg_level(cfg_level),
  .cfg_valid(cfg_valid)
);

// >>> tb/sbcirq_host_model.sv
// Host side of the interrupt pin: config drive and pulse measurement
`timescale 1ns/1ps
module sbcirq_host_model (
  input wire logic pclk,
  input wire logic int_pin_out,
  input wire logic int_pin_oe_n,
  input wire logic cfg_drive,
  output logic pin_level,
  output int n_pulse,
  output int low_len,
  output int gap_len
);
  int lo_r; // Low samples so far
  int hi_r; // High samples so far
  logic prev_r = 1'b1; // Pin level at the last edge
  // Host strap sets the level while the device has released the pin
  assign pin_level = int_pin_oe_n ? cfg_drive : int_pin_out;
  // Count pulses, record width and the high time before each one
  always @(posedge pclk) begin
    prev_r <= pin_level;
    lo_r <= pin_level ? 0 : lo_r + 1;
    hi_r <= pin_level ? hi_r + 1 : 0;
    if (prev_r && !pin_level && !int_pin_oe_n) begin
      n_pulse <= n_pulse + 1;
      gap_len <= hi_r;
    end
    if (!prev_r && pin_level && !int_pin_oe_n) begin
      low_len <= lo_r;
    end
  end
endmodule

// >>> tb/sbcirq_top_bench.sv
// Self-checking bench for the interrupt pulse logic
`timescale 1ns/1ps
module sbcirq_top_bench;
  localparam int PW = 20; // Shortened pulse and gap length
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, wk_a, wk_b, wk_lvl;
  logic [31:0] pwdata, prdata, fail_v, rv;
  logic pin_out, oe_n, stop_req, cfg_level, cfg_valid, irq, pin, cfg_drive;
  int fails, n_tests, n_pulse, low_len, gap_len, p0;

  sbcirq_top #(.PULSE_CYC(PW), .GAP_CYC(PW)) sbcirq_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wake_evt_a(wk_a), .wake_evt_b(wk_b),
    .fail_evt(fail_v), .wake_level(wk_lvl), .int_pin_in(pin),
    .int_pin_out(pin_out), .int_pin_oe_n(oe_n), .stop_req(stop_req),
    .cfg_level(cfg_level), .cfg_valid(cfg_valid), .irq(irq));
  sbcirq_host_model sbcirq_host_model_inst (
    .pclk(pclk), .int_pin_out(pin_out), .int_pin_oe_n(oe_n),
    .cfg_drive(cfg_drive), .pin_level(pin), .n_pulse(n_pulse),
    .low_len(low_len), .gap_len(gap_len));

  // ==========================================================
  // Clock, closing and helper tasks
  // ==========================================================
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // One APB transfer; holds the request until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0000_0000);
    chk(rv, exp, m);
  endtask
  // One-cycle event on the wake and failure inputs
  task ev(input logic [7:0] a, input logic [7:0] b, input logic [31:0] f);
    @(posedge pclk);
    wk_a <= a;
    wk_b <= b;
    fail_v <= f;
    @(posedge pclk);
    wk_a <= 8'h00;
    wk_b <= 8'h00;
    fail_v <= 32'h0000_0000;
  endtask
  // Wait past two pulses and a gap, then compare the pulse count
  task pulses(input int n, input string m);
    repeat (3 * PW + 20) @(posedge pclk);
    chk(n_pulse - p0, n, m);
    p0 = n_pulse;
  endtask
  task clr;
    wr(sbcirq_pkg::OFF_WK_A, 32'hFFFF_FFFF);
    wr(sbcirq_pkg::OFF_WK_B, 32'hFFFF_FFFF);
    wr(sbcirq_pkg::OFF_FAIL, 32'hFFFF_FFFF);
  endtask

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_of_test;
  end

  // ==========================================================
  // Test sequence
  // ==========================================================
  initial begin
    {psel, penable, pwrite, presetn, paddr, pwdata} = '0;
    {wk_a, wk_b, wk_lvl, fail_v} = '0;
    cfg_drive = 1'b1;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(sbcirq_pkg::OFF_CTRL, sbcirq_pkg::CTRL_RST, "ctrl reset");
    rd(sbcirq_pkg::OFF_WK_EN, sbcirq_pkg::WK_EN_RST, "enable reset");
    chk(oe_n, 1'b1, "pin released");
    repeat (280) @(posedge pclk);
    chk(cfg_valid, 1'b0, "config too early");
    for (int i = 0; i < 200 && cfg_valid !== 1'b1; i++) @(posedge pclk);
    rd(sbcirq_pkg::OFF_CFG, 32'h0000_0003, "config captured");
    chk(cfg_level, 1'b1, "config level output");
    $display("test config done");
    wr(sbcirq_pkg::OFF_CTRL, 32'h0000_0000);
    @(posedge pclk);
    chk(oe_n, 1'b0, "pin driven");
    p0 = n_pulse;
    ev(8'h01, 8'h00, 32'h0000_0000);
    pulses(0, "disabled source");
    ev(8'h00, 8'h00, 32'h0000_0100);
    pulses(0, "failure in wake class");
    clr;
    wr(sbcirq_pkg::OFF_WK_EN, 32'h0001_0001);
    ev(8'h01, 8'h00, 32'h0000_0000);
    repeat (5) @(posedge pclk);
    ev(8'h00, 8'h01, 32'h0000_0000);
    pulses(2, "pending event");
    chk(low_len, PW, "pulse width");
    chk(gap_len >= PW, 1, "gap");
    rd(sbcirq_pkg::OFF_WK_A, 32'h0000_0001, "wake a kept");
    rd(sbcirq_pkg::OFF_WK_B, 32'h0000_0001, "wake b updated");
    wr(sbcirq_pkg::OFF_WK_A, 32'h0000_0001);
    rd(sbcirq_pkg::OFF_WK_A, 32'h0000_0000, "wake a cleared");
    $display("test wake done");
    wr(sbcirq_pkg::OFF_CTRL, 32'h0000_0002);
    @(negedge pclk);
    chk(stop_req, 1'b1, "stop strobe out");
    pulses(1, "stop with wake set");
    wr(sbcirq_pkg::OFF_WK_B, 32'h0000_0001);
    wr(sbcirq_pkg::OFF_CTRL, 32'h0000_0002);
    pulses(0, "stop with wake clear");
    $display("test stop done");
    wr(sbcirq_pkg::OFF_CTRL, 32'h0000_0001);
    clr;
    ev(8'h00, 8'h00, 32'h0000_00FF);
    wk_lvl <= 8'hFF;
    pulses(0, "excluded sources");
    rd(sbcirq_pkg::OFF_LVL, 32'h0000_00FF, "level shown");
    clr;
    ev(8'h00, 8'h00, 32'h0000_0100);
    pulses(1, "failure in global class");
    rd(sbcirq_pkg::OFF_FAIL, 32'h0000_0100, "failure kept");
    rd(sbcirq_pkg::OFF_CTRL, 32'h0000_0001, "mode kept");
    $display("test global done");
    wr(sbcirq_pkg::OFF_IMASK, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0, "irq masked");
    wr(sbcirq_pkg::OFF_IMASK, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1, "irq raised");
    wr(sbcirq_pkg::OFF_ISTAT, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0, "irq cleared");
    wr(sbcirq_pkg::OFF_IMASK, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1, "irq config event");
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0000_0000, "unmapped");
    chk(pslverr, 1'b0, "no error response");
    $display("test regs done");
    end_of_test;
  end
endmodule
